/* rtl/llmcr_err_rate.v */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// 8b/10b error-rate checker
// ---------------------------------------------------------------
`include "llmcr_map.vh"
module llmcr_err_rate (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   input  wire        ce,
   input  wire        clear,
   // configuration
   input  wire        enable,
   input  wire [15:0] timerValue,
   input  wire [1:0]  threshSel,
   // events
   input  wire        errPulse,
   // result
   output reg         rateOk,
   output reg         periodDone
);
   reg  [15:0] timer_r;
   reg  [9:0]  errCount_r;
   reg  [9:0]  limit;

   always @* begin
      case (threshSel)
         2'h0:    limit = `LLMCR_THRESH_0;
         2'h1:    limit = `LLMCR_THRESH_1;
         2'h2:    limit = `LLMCR_THRESH_2;
         default: limit = `LLMCR_THRESH_3;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_r    <= `LLMCR_RST_ERR_TIMER;
         errCount_r <= 10'h000;
         rateOk     <= 1'b0;
         periodDone <= 1'b0;
      end else if (ce) begin
         periodDone <= 1'b0;
         if (clear || !enable) begin
            timer_r    <= timerValue;
            errCount_r <= 10'h000;
            rateOk     <= 1'b0;
         end else if (timer_r == 16'h0000) begin
            rateOk     <= (errCount_r < limit);
            periodDone <= 1'b1;
            // an error in the expiry cycle opens the next period, so none is lost
            errCount_r <= {9'h000, errPulse};
            timer_r    <= timerValue;
         end else begin
            timer_r <= timer_r - 16'h0001;
            if (errPulse && errCount_r != 10'h3FF) begin
               errCount_r <= errCount_r + 10'h001;
            end
         end
      end
   end
endmodule

/* rtl/llmcr_map.vh */
`ifndef LLMCR_MAP_VH
`define LLMCR_MAP_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LLMCR_OFS_LANE_MON_CFG  5'h0C
`define LLMCR_OFS_ERR_TIMER     5'h0D
`define LLMCR_OFS_CHAN_RESET    5'h0E
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LLMCR_RST_LANE_MON_CFG  16'h03F0
`define LLMCR_RST_ERR_TIMER     16'hFFFF
`define LLMCR_RST_CHAN_RESET    16'h0000
// ---------------------------------------------------------------
// lane_monitor_config fields
// ---------------------------------------------------------------
`define LLMCR_RSVD_HI_MSB       15
`define LLMCR_RSVD_HI_LSB       14
`define LLMCR_LANE_SEL_MSB      13
`define LLMCR_LANE_SEL_LSB      12
`define LLMCR_HYS_SEL_MSB       11
`define LLMCR_HYS_SEL_LSB       10
`define LLMCR_SPACING_MSB       9
`define LLMCR_SPACING_LSB       8
`define LLMCR_DEC_MASK_BIT      7
`define LLMCR_RSVD_LO_BIT       6
`define LLMCR_SIG_MASK_BIT      5
`define LLMCR_LOCK_MASK_BIT     4
`define LLMCR_REALIGN_BIT       2
`define LLMCR_THRESH_MSB        1
`define LLMCR_THRESH_LSB        0
// ---------------------------------------------------------------
// channel_reset_control fields
// ---------------------------------------------------------------
`define LLMCR_DP_RESET_BIT      3
`define LLMCR_TX_CLEAR_BIT      2
`define LLMCR_RX_CLEAR_BIT      1
// ---------------------------------------------------------------
// encodings and counts
// ---------------------------------------------------------------
`define LLMCR_HYS_STANDARD      2'h0
`define LLMCR_SPACING_8         5'h08
`define LLMCR_SPACING_16        5'h10
`define LLMCR_SPACING_24        5'h18
`define LLMCR_THRESH_0          10'h001
`define LLMCR_THRESH_1          10'h00F
`define LLMCR_THRESH_2          10'h07F
`define LLMCR_THRESH_3          10'h3FF
`define LLMCR_ACQUIRE_COMMAS    2'h3
`define LLMCR_STD_ERR_LIMIT     3'h4
`define LLMCR_STD_GOOD_RUN      2'h3
`endif

/* rtl/llmcr_regs.v */
`timescale 1ns/1ps
`include "llmcr_map.vh"
module llmcr_regs (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   input  wire        ce,
   // management register port
   input  wire [4:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrEn,
   input  wire        regRdEn,
   output reg  [15:0] regRdData,
   // decoded character stream
   input  wire        codeValid,
   input  wire        codeErr,
   input  wire        commaChar,
   input  wire        alignChar,
   // lane status
   input  wire [3:0]  laneAlignStatus,
   input  wire [3:0]  laneEnable,
   input  wire [3:0]  laneDecodeErr,
   input  wire [3:0]  signalAbsent,
   input  wire        lsPllLock,
   input  wire        hwRateCheckEn,
   // status outputs
   output reg         reportedLaneStatus,
   output reg         channelSync,
   output reg         laneAligned,
   output reg         linkOk,
   output wire        ratePeriodDone,
   // resets and clears
   output wire        datapathReset,
   output wire        transmitBufferClear,
   output wire        receiveBufferClear,
   output wire        forceRealign
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [15:0] laneMonCfg_r;
   reg  [15:0] errTimer_r;
   reg  [2:0]  chanReset_r;
   wire        wrCfg   = regWrEn && regAddr == `LLMCR_OFS_LANE_MON_CFG;
   wire        wrTimer = regWrEn && regAddr == `LLMCR_OFS_ERR_TIMER;
   wire        wrReset = regWrEn && regAddr == `LLMCR_OFS_CHAN_RESET;

   wire [1:0]  laneSel      = laneMonCfg_r[`LLMCR_LANE_SEL_MSB:`LLMCR_LANE_SEL_LSB];
   wire [1:0]  hysSel       = laneMonCfg_r[`LLMCR_HYS_SEL_MSB:`LLMCR_HYS_SEL_LSB];
   wire [1:0]  spacingSel   = laneMonCfg_r[`LLMCR_SPACING_MSB:`LLMCR_SPACING_LSB];
   wire        decodeMask   = laneMonCfg_r[`LLMCR_DEC_MASK_BIT];
   wire        sigAbsMask   = laneMonCfg_r[`LLMCR_SIG_MASK_BIT];
   wire        lockMask     = laneMonCfg_r[`LLMCR_LOCK_MASK_BIT];
   wire [1:0]  threshSel    = laneMonCfg_r[`LLMCR_THRESH_MSB:`LLMCR_THRESH_LSB];

   assign forceRealign        = laneMonCfg_r[`LLMCR_REALIGN_BIT];
   assign datapathReset       = chanReset_r[2];
   assign transmitBufferClear = chanReset_r[1];
   assign receiveBufferClear  = chanReset_r[0];

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         laneMonCfg_r <= `LLMCR_RST_LANE_MON_CFG;
         errTimer_r   <= `LLMCR_RST_ERR_TIMER;
         chanReset_r  <= 3'h0;
      end else if (ce) begin
         // self-clearing bits drop one cycle after being set
         laneMonCfg_r[`LLMCR_REALIGN_BIT] <= 1'b0;
         chanReset_r <= 3'h0;
         if (wrCfg) begin
            laneMonCfg_r[15:4] <= regWrData[15:4];
            laneMonCfg_r[`LLMCR_REALIGN_BIT] <= regWrData[`LLMCR_REALIGN_BIT];
            laneMonCfg_r[1:0]  <= regWrData[1:0];
         end
         if (wrTimer) begin
            errTimer_r <= regWrData;
         end
         if (wrReset) begin
            chanReset_r <= {regWrData[`LLMCR_DP_RESET_BIT],
                            regWrData[`LLMCR_TX_CLEAR_BIT],
                            regWrData[`LLMCR_RX_CLEAR_BIT]};
         end
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 16'h0_000;
      end else if (ce && regRdEn) begin
         case (regAddr)
            `LLMCR_OFS_LANE_MON_CFG: regRdData <= {laneMonCfg_r[15:3], 1'b0, laneMonCfg_r[1:0]};
            `LLMCR_OFS_ERR_TIMER:    regRdData <= errTimer_r;
            `LLMCR_OFS_CHAN_RESET:   regRdData <= {12'h000, chanReset_r, 1'b0};
            default:                 regRdData <= 16'h0_000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // asynchronous status pins
   // ---------------------------------------------------------------
   reg  [4:0]  pinMeta_r;
   reg  [4:0]  pinSync_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta_r <= 5'h0_0;
         pinSync_r <= 5'h0_0;
      end else if (ce) begin
         pinMeta_r <= {lsPllLock, signalAbsent};
         pinSync_r <= pinMeta_r;
      end
   end
   wire        pllLockS    = pinSync_r[4];
   wire [3:0]  sigAbsentS  = pinSync_r[3:0];

   // ---------------------------------------------------------------
   // channel sync state machine
   // ---------------------------------------------------------------
   localparam [1:0] SYNC_LOSS = 2'h1;
   localparam [1:0] SYNC_OK   = 2'h2;
   reg  [1:0]  syncState_r;
   reg  [1:0]  acqCnt_r;
   reg  [2:0]  errRun_r;
   reg  [1:0]  goodRun_r;
   wire [2:0]  errRunInc = errRun_r + 3'h1;
   reg  [2:0]  errLimit;

   always @* begin
      case (hysSel)
         2'h1:    errLimit = 3'h1;
         2'h2:    errLimit = 3'h2;
         2'h3:    errLimit = 3'h3;
         default: errLimit = `LLMCR_STD_ERR_LIMIT;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncState_r <= SYNC_LOSS;
         acqCnt_r    <= 2'h0;
         errRun_r    <= 3'h0;
         goodRun_r   <= 2'h0;
      end else if (ce) begin
         if (datapathReset) begin
            syncState_r <= SYNC_LOSS;
            acqCnt_r    <= 2'h0;
            errRun_r    <= 3'h0;
            goodRun_r   <= 2'h0;
         end else if (codeValid) begin
            case (syncState_r)
               SYNC_LOSS: begin
                  errRun_r  <= 3'h0;
                  goodRun_r <= 2'h0;
                  if (codeErr) begin
                     acqCnt_r <= 2'h0;
                  end else if (commaChar) begin
                     if (acqCnt_r == `LLMCR_ACQUIRE_COMMAS - 2'h1) begin
                        acqCnt_r    <= 2'h0;
                        syncState_r <= SYNC_OK;
                     end else begin
                        acqCnt_r <= acqCnt_r + 2'h1;
                     end
                  end
               end
               SYNC_OK: begin
                  if (codeErr) begin
                     goodRun_r <= 2'h0;
                     if (errRunInc >= errLimit) begin
                        syncState_r <= SYNC_LOSS;
                        errRun_r    <= 3'h0;
                     end else begin
                        errRun_r <= errRunInc;
                     end
                  end else if (hysSel != `LLMCR_HYS_STANDARD) begin
                     errRun_r <= 3'h0;
                  end else if (errRun_r != 3'h0) begin
                     // a run of good codes forgives one error
                     if (goodRun_r == `LLMCR_STD_GOOD_RUN) begin
                        errRun_r  <= errRun_r - 3'h1;
                        goodRun_r <= 2'h0;
                     end else begin
                        goodRun_r <= goodRun_r + 2'h1;
                     end
                  end
               end
               default: begin
                  syncState_r <= SYNC_LOSS;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // lane alignment slave
   // ---------------------------------------------------------------
   localparam [1:0] ALN_SEARCH = 2'h1;
   localparam [1:0] ALN_LOCKED = 2'h2;
   reg  [1:0]  alnState_r;
   reg  [4:0]  charCnt_r;
   reg         alignSeen_r;
   reg  [4:0]  minSpacing;
   wire        spacingOk = charCnt_r >= minSpacing;

   always @* begin
      case (spacingSel)
         2'h0:    minSpacing = `LLMCR_SPACING_8;
         2'h1:    minSpacing = `LLMCR_SPACING_16;
         default: minSpacing = `LLMCR_SPACING_24;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alnState_r  <= ALN_SEARCH;
         charCnt_r   <= 5'h0_0;
         alignSeen_r <= 1'b0;
      end else if (ce) begin
         if (datapathReset || forceRealign || syncState_r != SYNC_OK) begin
            alnState_r  <= ALN_SEARCH;
            charCnt_r   <= 5'h0_0;
            alignSeen_r <= 1'b0;
         end else if (codeValid) begin
            if (alignChar) begin
               charCnt_r <= 5'h0_0;
            end else if (charCnt_r != 5'h1_F) begin
               charCnt_r <= charCnt_r + 5'h0_1;
            end
            case (alnState_r)
               ALN_SEARCH: begin
                  if (alignChar) begin
                     alignSeen_r <= 1'b1;
                     if (alignSeen_r && spacingOk) begin
                        alnState_r <= ALN_LOCKED;
                     end
                  end
               end
               ALN_LOCKED: begin
                  if (alignChar && !spacingOk) begin
                     alnState_r  <= ALN_SEARCH;
                     alignSeen_r <= 1'b1;
                  end
               end
               default: begin
                  alnState_r <= ALN_SEARCH;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // error-rate check and link status
   // ---------------------------------------------------------------
   reg         decErrPulse_r;
   wire        rateOk;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         decErrPulse_r <= 1'b0;
      end else if (ce) begin
         decErrPulse_r <= |(laneDecodeErr & laneEnable) && !decodeMask;
      end
   end

   llmcr_err_rate u_errRate (
      .clk        (clk),
      .reset_n    (reset_n),
      .ce         (ce),
      .clear      (datapathReset),
      .enable     (hwRateCheckEn),
      .timerValue (errTimer_r),
      .threshSel  (threshSel),
      .errPulse   (decErrPulse_r),
      .rateOk     (rateOk),
      .periodDone (ratePeriodDone)
   );

   wire lockTerm   = lockMask || pllLockS;
   wire sigTerm    = sigAbsMask || !(|(sigAbsentS & laneEnable));
   wire rateTerm   = decodeMask || !hwRateCheckEn || rateOk;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reportedLaneStatus <= 1'b0;
         channelSync        <= 1'b0;
         laneAligned        <= 1'b0;
         linkOk             <= 1'b0;
      end else if (ce) begin
         reportedLaneStatus <= laneAlignStatus[laneSel];
         channelSync        <= syncState_r == SYNC_OK;
         laneAligned        <= alnState_r == ALN_LOCKED;
         linkOk             <= !datapathReset && alnState_r == ALN_LOCKED &&
                               lockTerm && sigTerm && rateTerm;
      end
   end
endmodule

/* sim/llmcr_mgmt_host.sv */
`timescale 1ns/1ps
module llmcr_mgmt_host (
   // clock
   input  wire        clk,
   // register port
   output reg  [4:0]  regAddr,
   output reg  [15:0] regWrData,
   output reg         regWrEn,
   output reg         regRdEn,
   input  wire [15:0] regRdData
);
   initial begin
      regAddr = 5'h00;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // idle bus shows inverted values so stale data never looks valid
   task wr(input [4:0] a, input [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~v;
   endtask
   task rd(input [4:0] a, output [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1 v = regRdData;
   endtask
   task config_done;
      wr(5'h0E, 16'h0008);
   endtask
endmodule

/* sim/llmcr_regs_monitor.sv */
`timescale 1ns/1ps
module llmcr_regs_chk (
   // clock and reset
   input wire        clk,
   input wire        reset_n,
   input wire        ce,
   // register port
   input wire [4:0]  regAddr,
   input wire [15:0] regWrData,
   input wire        regWrEn,
   // status
   input wire [3:0]  laneAlignStatus,
   input wire        hwRateCheckEn,
   input wire        reportedLaneStatus,
   input wire        linkOk,
   input wire        ratePeriodDone,
   // resets and clears
   input wire        datapathReset,
   input wire        transmitBufferClear,
   input wire        receiveBufferClear,
   input wire        forceRealign
);
   wire wrC = ce && regWrEn && regAddr == 5'h0C;
   wire wrE = ce && regWrEn && regAddr == 5'h0E;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_dp_reset_set: assert property (
      wrE && regWrData[3] |=> datapathReset) else $error("datapath reset pulse missing");
   a_tx_clear_set: assert property (
      wrE && regWrData[2] |=> transmitBufferClear) else $error("tx clear pulse missing");
   a_rx_clear_set: assert property (
      wrE && regWrData[1] |=> receiveBufferClear) else $error("rx clear pulse missing");
   a_realign_set: assert property (
      wrC && regWrData[2] |=> forceRealign) else $error("realign pulse missing");
   a_dp_self_clear: assert property (
      ce && datapathReset && !(wrE && regWrData[3]) |=> !datapathReset)
      else $error("datapath reset stuck");
   a_realign_self_clear: assert property (
      ce && forceRealign && !(wrC && regWrData[2]) |=> !forceRealign)
      else $error("realign stuck");
   a_link_dp_low: assert property (
      ce && datapathReset |=> !linkOk) else $error("link ok after datapath reset");
   a_tx_self_clear: assert property (
      ce && transmitBufferClear && !(wrE && regWrData[2]) |=> !transmitBufferClear)
      else $error("tx clear stuck");
   a_rx_self_clear: assert property (
      ce && receiveBufferClear && !(wrE && regWrData[1]) |=> !receiveBufferClear)
      else $error("rx clear stuck");
   a_lane_none_set: assert property (
      $past(ce) && $past(reset_n) && $past(laneAlignStatus) == 4'h0 |-> !reportedLaneStatus)
      else $error("reported lane status high");
   a_lane_all_set: assert property (
      $past(ce) && $past(reset_n) && $past(laneAlignStatus) == 4'hF |-> reportedLaneStatus)
      else $error("reported lane status low");
   a_rate_off_quiet: assert property (
      $past(ce) && $past(reset_n) && !$past(hwRateCheckEn) |-> !ratePeriodDone)
      else $error("rate period pulse while disabled");
endmodule
bind llmcr_regs llmcr_regs_chk u_llmcr_regs_chk (.clk(clk), .reset_n(reset_n), .ce(ce),
   .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .laneAlignStatus(laneAlignStatus), .hwRateCheckEn(hwRateCheckEn),
   .reportedLaneStatus(reportedLaneStatus), .linkOk(linkOk), .ratePeriodDone(ratePeriodDone),
   .datapathReset(datapathReset), .transmitBufferClear(transmitBufferClear),
   .receiveBufferClear(receiveBufferClear), .forceRealign(forceRealign));

/* sim/llmcr_regs_tb.sv */
`timescale 1ns/1ps
module llmcr_regs_tb;
   reg        clk = 0, reset_n = 0, ce = 1, lsPllLock = 0, hwRateCheckEn = 0;
   reg        codeValid = 0, codeErr = 0, commaChar = 0, alignChar = 0;
   reg  [3:0] laneAlignStatus = 0, laneEnable = 4'hF, laneDecodeErr = 0, signalAbsent = 0;
   wire [4:0] regAddr;
   wire [15:0] regWrData, regRdData;
   wire       regWrEn, regRdEn, reportedLaneStatus, channelSync, laneAligned, linkOk;
   wire       ratePeriodDone, datapathReset, transmitBufferClear, receiveBufferClear;
   wire       forceRealign;
   int        badCount = 0, checkCount = 0, cyc = 0, i, n, lim;
   logic [15:0] d;
   always #5 clk = ~clk;
   llmcr_regs u_llmcr_regs (.clk(clk), .reset_n(reset_n), .ce(ce), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .codeValid(codeValid), .codeErr(codeErr), .commaChar(commaChar), .alignChar(alignChar),
      .laneAlignStatus(laneAlignStatus), .laneEnable(laneEnable), .laneDecodeErr(laneDecodeErr),
      .signalAbsent(signalAbsent), .lsPllLock(lsPllLock), .hwRateCheckEn(hwRateCheckEn),
      .reportedLaneStatus(reportedLaneStatus), .channelSync(channelSync),
      .laneAligned(laneAligned), .linkOk(linkOk), .ratePeriodDone(ratePeriodDone),
      .datapathReset(datapathReset), .transmitBufferClear(transmitBufferClear),
      .receiveBufferClear(receiveBufferClear), .forceRealign(forceRealign));
   llmcr_mgmt_host u_llmcr_mgmt_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task conclude;
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         badCount++;
         conclude;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rdc(input logic [4:0] a, input logic [15:0] exp);
      u_llmcr_mgmt_host.rd(a, d);
      chk(d, exp);
   endtask
   task wcyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task send(input int k, input logic cm, input logic er, input logic al);
      repeat (k) begin
         @(posedge clk);
         codeValid <= 1'b1;
         commaChar <= cm;
         codeErr <= er;
         alignChar <= al;
      end
      @(posedge clk);
      codeValid <= 1'b0;
   endtask
   task acquire;
      u_llmcr_mgmt_host.config_done;
      wcyc(3);
      chk(channelSync, 1'b0);
      send(3, 1, 0, 0);
      wcyc(3);
      chk(channelSync, 1'b1);
   endtask
   task align(input int k);
      send(1, 0, 0, 1);
      send(k, 0, 0, 0);
      send(1, 0, 0, 1);
      wcyc(3);
   endtask
   task waitdone(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (ratePeriodDone !== 1'b1 && c < 2000);
   endtask
   task burst(input int k);
      if (k > 0) begin
         @(posedge clk);
         laneDecodeErr <= 4'h1;
         repeat (k) @(posedge clk);
         laneDecodeErr <= 4'h0;
      end
   endtask
   function automatic [15:0] cw(input [1:0] sel, input [1:0] hys, input [1:0] sp,
                                input [2:0] m, input [1:0] th);
      cw = {2'b00, sel, hys, sp, m[2], 1'b1, m[1], m[0], 2'b00, th};
   endfunction
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rdc(5'h0C, 16'h03F0);
      rdc(5'h0D, 16'hFFFF);
      rdc(5'h0E, 16'h0000);
      rdc(5'h1F, 16'h0000);
      $display("test defaults done");
      u_llmcr_mgmt_host.wr(5'h0C, 16'hFFFF);
      #1 chk(forceRealign, 1'b1);
      wcyc(1);
      chk(forceRealign, 1'b0);
      rdc(5'h0C, 16'hFFF3);
      u_llmcr_mgmt_host.wr(5'h0D, 16'h0500);
      rdc(5'h0D, 16'h0500);
      u_llmcr_mgmt_host.wr(5'h0E, 16'h000E);
      #1 chk({datapathReset, transmitBufferClear, receiveBufferClear}, 3'b111);
      wcyc(1);
      chk({datapathReset, transmitBufferClear, receiveBufferClear}, 3'b000);
      rdc(5'h0C, 16'hFFF3);
      u_llmcr_mgmt_host.wr(5'h0E, 16'h0004);
      #1 chk({datapathReset, transmitBufferClear, receiveBufferClear}, 3'b010);
      u_llmcr_mgmt_host.wr(5'h0E, 16'h0002);
      #1 chk({datapathReset, transmitBufferClear, receiveBufferClear}, 3'b001);
      ce <= 1'b0;
      u_llmcr_mgmt_host.wr(5'h0D, 16'h0123);
      ce <= 1'b1;
      #1 chk(receiveBufferClear, 1'b1);
      rdc(5'h0D, 16'h0500);
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         u_llmcr_mgmt_host.wr(5'h0C, cw(i, 0, 3, 7, 0));
         laneAlignStatus <= 4'h1 << i;
         wcyc(2);
         chk(reportedLaneStatus, 1'b1);
         laneAlignStatus <= ~(4'h1 << i);
         wcyc(2);
         chk(reportedLaneStatus, 1'b0);
      end
      laneAlignStatus <= 4'hF;
      $display("test lane select done");
      for (i = 0; i < 4; i++) begin
         u_llmcr_mgmt_host.wr(5'h0C, cw(0, i, 3, 7, 0));
         acquire;
         lim = (i == 0) ? 4 : i;
         if (lim > 1) begin
            send(lim - 1, 0, 1, 0);
            wcyc(3);
            chk(channelSync, 1'b1);
         end
         if (i == 0) begin
            send(4, 0, 0, 0);
            send(1, 0, 1, 0);
            wcyc(3);
            chk(channelSync, 1'b1);
         end
         send(1, 0, 1, 0);
         wcyc(3);
         chk(channelSync, 1'b0);
      end
      $display("test hysteresis done");
      for (i = 0; i < 4; i++) begin
         n = (i == 0) ? 8 : (i == 1) ? 16 : 24;
         u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, i, 7, 0));
         acquire;
         align(n - 1);
         chk(laneAligned, 1'b0);
         send(n, 0, 0, 0);
         send(1, 0, 0, 1);
         wcyc(3);
         chk(laneAligned, 1'b1);
      end
      u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, 3, 7, 0) | 16'h0004);
      wcyc(3);
      chk(laneAligned, 1'b0);
      align(24);
      chk(laneAligned, 1'b1);
      $display("test alignment done");
      chk(linkOk, 1'b1);
      u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, 3, 3'b110, 0));
      wcyc(3);
      chk(linkOk, 1'b0);
      lsPllLock <= 1'b1;
      wcyc(5);
      chk(linkOk, 1'b1);
      u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, 3, 3'b100, 0));
      signalAbsent <= 4'h4;
      wcyc(5);
      chk(linkOk, 1'b0);
      laneEnable <= 4'h3;
      wcyc(5);
      chk(linkOk, 1'b1);
      laneEnable <= 4'hF;
      signalAbsent <= 4'h0;
      $display("test link status done");
      hwRateCheckEn <= 1'b1;
      for (i = 0; i < 4; i++) begin
         lim = (i == 0) ? 1 : (i == 1) ? 15 : (i == 2) ? 127 : 1023;
         u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, 3, 3'b000, i));
         waitdone(n);
         waitdone(n);
         chk(n, 16'h0500 + 16'h0001);
         burst(lim - 1);
         waitdone(n);
         wcyc(2);
         chk(linkOk, 1'b1);
         burst(lim);
         waitdone(n);
         wcyc(2);
         chk(linkOk, 1'b0);
      end
      u_llmcr_mgmt_host.wr(5'h0C, cw(0, 0, 3, 3'b100, 0));
      burst(5);
      waitdone(n);
      wcyc(2);
      chk(linkOk, 1'b1);
      hwRateCheckEn <= 1'b0;
      waitdone(n);
      chk(n, 16'd2000);
      $display("test error rate done");
      conclude;
   end
endmodule
